// ---- pkg/tdc_readout_pkg.sv ----
package tdc_readout_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] CTRL_OFFSET   = 16'h1000;  // Module control word
    localparam logic [15:0] STATUS_OFFSET = 16'h1002;  // Live status word
    localparam logic [15:0] CTRL_RESET    = 16'h0020;  // Correction on, timestamp off
    localparam int          CORR_EN_BIT   = 5;         // Nonlinearity correction enable
    localparam int          STAMP_BIT_A   = 9;         // Timestamp enable, first half
    localparam int          STAMP_BIT_B   = 11;        // Timestamp enable, second half
    localparam logic [15:0] STAMP_MASK    = 16'h0A00;  // Both timestamp bits
    // Status bit positions
    localparam int          ST_CONFIG_BIT = 0;
    localparam int          ST_FULL_BIT   = 1;
    localparam int          ST_PEND_BIT   = 2;
    localparam int          ST_FAULT_BIT  = 3;
    // ------------------------------------------------------------
    // Event word layout
    // ------------------------------------------------------------
    localparam logic [4:0]  STAMP_ID      = 5'h11;     // Id of the timestamp word
    localparam int          ID_LSB        = 27;        // Id sits in [31:27]
    localparam int          STAMP_HI_W    = 27;        // Upper timestamp bits in the word
    localparam int          STAMP_LO_W    = 5;         // Lower bits in the trailer
    localparam int          HIT_W         = 21;        // Hit value field [20:0]
    localparam int          LUT_AW        = 10;        // Bins per clock period index
    localparam int          LUT_DEPTH     = 1024;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS        = 20;                 // ref_clk period
    localparam int PULSE_NS      = 25;                 // Least width of control pulses
    localparam int TRIG_SPACE_NS = 75;                 // Least trigger spacing
    localparam int PULSE_CYCLES  = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int TRIG_CYCLES   = (TRIG_SPACE_NS + CLK_NS - 1) / CLK_NS;
    localparam int TICK_STEP     = 4;                  // 40 MHz out of 50 MHz
    localparam int TICK_MOD      = 5;
    localparam int CONFIG_CYCLES = 4000;               // Lamp test after power-on

    typedef enum logic [1:0] {
        KIND_HEADER  = 2'b00,
        KIND_DATUM   = 2'b01,
        KIND_TRAILER = 2'b10,
        KIND_OTHER   = 2'b11
    } word_kind_type;

    typedef enum logic [1:0] {
        HOST_IDLE  = 2'b00,
        HOST_PULSE = 2'b01,
        HOST_GAP   = 2'b10
    } host_state_type;
endpackage : tdc_readout_pkg

// ---- pkg/tdc_ctrl_if.sv ----
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Control connector pins plus register access port
// ------------------------------------------------------------
interface tdc_ctrl_if;
    logic        connector_trigger_in;  // Rising edge = trigger
    logic        hard_clear_in;         // High = clear
    logic        bunch_count_reset_in;  // Rising edge = bunch reset
    logic [15:0] addr;                  // Register address
    logic [15:0] wdata;                 // Write data
    logic        wr;                    // Write strobe
    logic        rd;                    // Read strobe
    logic [15:0] rdata;                 // Read data, cycle after rd

    modport device (
        input  connector_trigger_in, hard_clear_in, bunch_count_reset_in,
        input  addr, wdata, wr, rd,
        output rdata
    );
    modport host (
        output connector_trigger_in, hard_clear_in, bunch_count_reset_in,
        output addr, wdata, wr, rd,
        input  rdata
    );
endinterface : tdc_ctrl_if
`default_nettype wire

// ---- core/tdc_readout_device.sv ----
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module tdc_readout_device #(
    parameter int CONFIG_CYCLES = tdc_readout_pkg::CONFIG_CYCLES,
    parameter int LUT_W         = 8
) (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    tdc_ctrl_if.device       ctrl,
    input  wire logic        front_trigger_in,  // Front panel pin
    input  wire logic        ext_clock_in,      // External clock pin
    input  wire logic        ext_clock_sel,     // Switch: 1 = external clock
    input  wire logic        term_switch,       // Switch: bus terminated
    input  wire logic        flash_wr,          // Table word from flash loader
    input  wire logic [9:0]  flash_addr,
    input  wire logic [7:0]  flash_data,
    input  wire logic        flash_done,        // Flash load finished
    input  wire logic [31:0] ev_word,           // Event word from converters
    input  wire logic [1:0]  ev_kind,
    input  wire logic        ev_valid,
    output logic             ev_ready,
    output logic [31:0] out_word,
    output logic        out_valid,
    input  wire logic        buf_full,          // Output buffer full
    input  wire logic        buf_pending,       // Datum or event held
    input  wire logic        global_error,      // Converter global error
    output logic             bunch_reset_pulse,
    output logic             trigger_pulse,
    output logic             clear_active,
    output logic             full_lamp,
    output logic             fault_lamp,
    output logic             data_pending_lamp,
    output logic             ack_lamp,
    output logic             term_lamp
);
    // Refuse parameter values the logic cannot serve
    if (LUT_W < 1 || LUT_W > tdc_readout_pkg::HIT_W) begin : g_bad_lut_w
        $error("LUT_W out of range");
    end
    if (CONFIG_CYCLES < 1) begin : g_bad_config
        $error("CONFIG_CYCLES must be positive");
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] s_trg_f, s_trg_c, s_clr, s_bun, s_clk, s_term, s_sel;  // Two-flop chains
    logic       trg_d, bun_d, clk_d;                            // Edge history
    always_ff @(posedge ref_clk) begin
        s_trg_f <= {s_trg_f[0], front_trigger_in};
        s_trg_c <= {s_trg_c[0], ctrl.connector_trigger_in};
        s_clr   <= {s_clr[0], ctrl.hard_clear_in};
        s_bun   <= {s_bun[0], ctrl.bunch_count_reset_in};
        s_clk   <= {s_clk[0], ext_clock_in};
        s_term  <= {s_term[0], term_switch};
        s_sel   <= {s_sel[0], ext_clock_sel};  // Switch may move at any time
    end

    // Both trigger sources merged after synchronising
    logic trg_any;
    assign trg_any = s_trg_f[1] | s_trg_c[1];

    // Clear acts as reset for the readout path while high
    logic clr_rst;
    assign clr_rst = !reset_n || s_clr[1];

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            trg_d <= 1'b0;
            bun_d <= 1'b0;
            clk_d <= 1'b0;
        end else begin
            trg_d <= trg_any;
            bun_d <= s_bun[1];
            clk_d <= s_clk[1];
        end
    end

    logic trg_rise, bun_rise, clk_rise;
    assign trg_rise = trg_any & ~trg_d;
    assign bun_rise = s_bun[1] & ~bun_d;
    assign clk_rise = s_clk[1] & ~clk_d;

    // ------------------------------------------------------------
    // Timestamp counter
    // ------------------------------------------------------------
    // Internal 40 MHz rate comes from 4 enables in every 5 cycles;
    // jitter is one ref_clk period, averaged out over the count.
    logic [2:0]  tick_phase;
    logic        tick;
    logic [31:0] stamp_count;   // Free running
    logic [31:0] stamp_latch;   // Value at last trigger
    assign tick = s_sel[1] ? clk_rise : (tick_phase != 3'h0);

    always_ff @(posedge ref_clk) begin
        if (clr_rst) begin
            tick_phase <= 3'h0;
        end else if (tick_phase == 3'(tdc_readout_pkg::TICK_MOD - 1)) begin
            tick_phase <= 3'h0;
        end else begin
            tick_phase <= tick_phase + 3'h1;
        end
    end

    // Counter advances on tick and is latched on trigger
    always_ff @(posedge ref_clk) begin
        if (clr_rst) begin
            stamp_count <= 32'h00000000;
            stamp_latch <= 32'h00000000;
        end else begin
            if (tick) begin
                stamp_count <= stamp_count + 32'h00000001;
            end
            if (trg_rise) begin
                stamp_latch <= stamp_count;
            end
        end
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    logic [15:0] module_control;  // Software control word
    logic        configuring;     // Power-on configuration under way
    logic        stamp_on, corr_on;
    assign stamp_on = (module_control & tdc_readout_pkg::STAMP_MASK) == tdc_readout_pkg::STAMP_MASK;
    assign corr_on  = module_control[tdc_readout_pkg::CORR_EN_BIT];

    // Control word; only the power reset restores it, clear does not
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            module_control <= tdc_readout_pkg::CTRL_RESET;
        end else if (ctrl.wr && ctrl.addr == tdc_readout_pkg::CTRL_OFFSET) begin
            module_control <= ctrl.wdata;
        end
    end

    // Read data valid the cycle after the strobe; unmapped reads zero
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ctrl.rdata <= 16'h0000;
        end else if (ctrl.rd) begin
            case (ctrl.addr)
                tdc_readout_pkg::CTRL_OFFSET:   ctrl.rdata <= module_control;
                tdc_readout_pkg::STATUS_OFFSET: ctrl.rdata <= {12'h000, global_error, buf_pending,
                                                              buf_full, configuring};
                default:                        ctrl.rdata <= 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Correction table
    // ------------------------------------------------------------
    // One entry per bin of a clock period, since the error repeats
    logic signed [LUT_W-1:0] lut_mem [tdc_readout_pkg::LUT_DEPTH];
    always_ff @(posedge ref_clk) begin
        if (flash_wr) begin
            lut_mem[flash_addr] <= LUT_W'(signed'(flash_data));
        end
    end

    // Corrected hit value, upper word bits kept
    function automatic logic [31:0] correct_hit(input logic [31:0] w, input logic signed [LUT_W-1:0] e);
        logic [20:0] v;
        v = w[20:0] - 21'(e);
        return {w[31:21], v};
    endfunction

    // ------------------------------------------------------------
    // Event stream editing
    // ------------------------------------------------------------
    logic [31:0] held_trailer;   // Trailer waiting behind the stamp word
    logic        holding;
    logic        take;
    assign take = ev_valid && ev_ready;

    always_ff @(posedge ref_clk) begin
        if (clr_rst) begin
            out_word     <= 32'h00000000;
            out_valid    <= 1'b0;
            ev_ready     <= 1'b1;
            holding      <= 1'b0;
            held_trailer <= 32'h00000000;
        end else if (holding) begin
            // Second beat: trailer after the stamp word
            out_word  <= held_trailer;
            out_valid <= 1'b1;
            holding   <= 1'b0;
            ev_ready  <= 1'b1;
        end else if (take) begin
            out_valid <= 1'b1;
            case (ev_kind)
                tdc_readout_pkg::KIND_DATUM: begin
                    out_word <= corr_on ? correct_hit(ev_word, lut_mem[ev_word[9:0]]) : ev_word;
                end
                tdc_readout_pkg::KIND_TRAILER: begin
                    if (stamp_on) begin
                        out_word     <= {tdc_readout_pkg::STAMP_ID, stamp_latch[31:5]};
                        held_trailer <= {ev_word[31:5], stamp_latch[4:0]};
                        holding      <= 1'b1;
                        ev_ready     <= 1'b0;
                    end else begin
                        out_word <= ev_word;
                    end
                end
                default: begin
                    out_word <= ev_word;
                end
            endcase
        end else begin
            out_valid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Power-on configuration window
    // ------------------------------------------------------------
    logic [$clog2(CONFIG_CYCLES+1)-1:0] cfg_count;
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cfg_count   <= '0;
            configuring <= 1'b1;
        end else if (configuring) begin
            // Held until both the lamp time and the table load finish
            if (cfg_count != CONFIG_CYCLES[$bits(cfg_count)-1:0]) begin
                cfg_count <= cfg_count + 1'b1;
            end else if (flash_done) begin
                configuring <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Lamps and pulses, all registered
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            full_lamp         <= 1'b1;
            fault_lamp        <= 1'b1;
            data_pending_lamp <= 1'b1;
            ack_lamp          <= 1'b0;
            term_lamp         <= 1'b0;
            bunch_reset_pulse <= 1'b0;
            trigger_pulse     <= 1'b0;
            clear_active      <= 1'b0;
        end else begin
            full_lamp         <= buf_full || configuring;
            fault_lamp        <= global_error || configuring;
            data_pending_lamp <= buf_pending || configuring;
            ack_lamp          <= ctrl.wr || ctrl.rd;
            term_lamp         <= s_term[1];
            bunch_reset_pulse <= bun_rise;
            trigger_pulse     <= trg_rise;
            clear_active      <= s_clr[1];
        end
    end
endmodule : tdc_readout_device
`default_nettype wire

// ---- core/tdc_readout_host.sv ----
`timescale 1ns/1ns
`default_nettype none
module tdc_readout_host (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    tdc_ctrl_if.host         ctrl,
    input  wire logic        cmd_wr,       // Register write order
    input  wire logic        cmd_rd,       // Register read order
    input  wire logic [15:0] cmd_addr,
    input  wire logic [15:0] cmd_wdata,
    output logic [15:0] cmd_rdata,    // Read result
    output logic        cmd_rvalid,   // Result valid pulse
    input  wire logic        trig_req,     // Send a trigger pulse
    input  wire logic        clear_req,    // Send a clear pulse
    input  wire logic        bunch_req,    // Send a bunch reset pulse
    output logic             pulse_busy    // Pulse or spacing in progress
);
    // ------------------------------------------------------------
    // Register access, passed straight onto the port
    // ------------------------------------------------------------
    logic rd_d;  // Read issued last cycle
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ctrl.wr    <= 1'b0;
            ctrl.rd    <= 1'b0;
            ctrl.addr  <= 16'h0000;
            ctrl.wdata <= 16'h0000;
        end else begin
            // Write wins if both are requested; strobes never overlap
            ctrl.wr <= cmd_wr;
            ctrl.rd <= cmd_rd && !cmd_wr;
            if (cmd_wr || cmd_rd) begin
                ctrl.addr  <= cmd_addr;
                ctrl.wdata <= cmd_wdata;
            end
        end
    end

    // Read data is only valid the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rd_d       <= 1'b0;
            cmd_rvalid <= 1'b0;
            cmd_rdata  <= 16'h0000;
        end else begin
            rd_d       <= ctrl.rd;
            cmd_rvalid <= rd_d;
            if (rd_d) begin
                cmd_rdata <= ctrl.rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Control pulses
    // ------------------------------------------------------------
    // Every pulse stands at least 25 ns; triggers are kept 75 ns apart
    tdc_readout_pkg::host_state_type state;
    logic [2:0] count;
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state                     <= tdc_readout_pkg::HOST_IDLE;
            count                     <= 3'h0;
            ctrl.connector_trigger_in <= 1'b0;
            ctrl.hard_clear_in        <= 1'b0;
            ctrl.bunch_count_reset_in <= 1'b0;
            pulse_busy                <= 1'b0;
        end else begin
            case (state)
                tdc_readout_pkg::HOST_IDLE: begin
                    // Fixed priority: clear, bunch reset, trigger
                    if (clear_req || bunch_req || trig_req) begin
                        ctrl.hard_clear_in        <= clear_req;
                        ctrl.bunch_count_reset_in <= !clear_req && bunch_req;
                        ctrl.connector_trigger_in <= !clear_req && !bunch_req;
                        count      <= 3'(tdc_readout_pkg::PULSE_CYCLES - 1);
                        state      <= tdc_readout_pkg::HOST_PULSE;
                        pulse_busy <= 1'b1;
                    end
                end
                tdc_readout_pkg::HOST_PULSE: begin
                    if (count != 3'h0) begin
                        count <= count - 3'h1;
                    end else begin
                        ctrl.hard_clear_in        <= 1'b0;
                        ctrl.bunch_count_reset_in <= 1'b0;
                        ctrl.connector_trigger_in <= 1'b0;
                        // Low time so the next trigger edge is 100 ns on at the earliest
                        count <= 3'(tdc_readout_pkg::TRIG_CYCLES - tdc_readout_pkg::PULSE_CYCLES - 1);
                        state <= tdc_readout_pkg::HOST_GAP;
                    end
                end
                tdc_readout_pkg::HOST_GAP: begin
                    if (count != 3'h0) begin
                        count <= count - 3'h1;
                    end else begin
                        state      <= tdc_readout_pkg::HOST_IDLE;
                        pulse_busy <= 1'b0;
                    end
                end
                default: begin
                    state <= tdc_readout_pkg::HOST_IDLE;
                end
            endcase
        end
    end
endmodule : tdc_readout_host
`default_nettype wire

// ---- sim/tdc_ctrl_props.sv ----
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Control connector and register port checks
// ------------------------------------------------------------
module tdc_ctrl_props (
    input wire logic        ref_clk,
    input wire logic        reset_n,
    input wire logic        connector_trigger_in,
    input wire logic        hard_clear_in,
    input wire logic        bunch_count_reset_in,
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] rdata
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    logic [15:0] shadow;  // Control word as the host last set it
    // Clear does not touch the control word, so only reset reloads it
    always_ff @(posedge ref_clk) begin
        if (!reset_n)
            shadow <= tdc_readout_pkg::CTRL_RESET;
        else if (wr && addr == tdc_readout_pkg::CTRL_OFFSET)
            shadow <= wdata;
    end
    a_trig_width: assert property ($rose(connector_trigger_in) |=> connector_trigger_in ##1 !connector_trigger_in)
        else $error("trigger pin width wrong");
    a_trig_space: assert property ($rose(connector_trigger_in) |=> (!$rose(connector_trigger_in))[*3])
        else $error("trigger pins too close");
    a_clear_width: assert property ($rose(hard_clear_in) |=> hard_clear_in)
        else $error("clear pin too short");
    a_bunch_width: assert property ($rose(bunch_count_reset_in) |=> bunch_count_reset_in ##1 !bunch_count_reset_in)
        else $error("bunch reset pin width wrong");
    a_one_pin: assert property ($onehot0({connector_trigger_in, hard_clear_in, bunch_count_reset_in}))
        else $error("two control pins at once");
    a_ctrl_value: assert property (rd && addr == tdc_readout_pkg::CTRL_OFFSET |=> rdata == $past(shadow))
        else $error("control word read back wrong");
    a_unmapped_zero: assert property (rd && addr != tdc_readout_pkg::CTRL_OFFSET
        && addr != tdc_readout_pkg::STATUS_OFFSET |=> rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_reset_idle: assert property (disable iff (1'b0) !reset_n |=> !connector_trigger_in && !hard_clear_in)
        else $error("pins active in reset");
    // Main scenarios
    c_ctrl_write: cover property (wr && addr == tdc_readout_pkg::CTRL_OFFSET);
    c_trig: cover property ($rose(connector_trigger_in));
    c_clear: cover property ($rose(hard_clear_in));
endmodule : tdc_ctrl_props
`default_nettype wire

// ---- sim/tb_tdc_timetag_inl_readout.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_tdc_timetag_inl_readout;
    // ------------------------------------------------------------
    // Signals, all quiet at time zero
    // ------------------------------------------------------------
    logic ref_clk = 0, reset_n = 0, cmd_wr = 0, cmd_rd = 0, trig_req = 0, clear_req = 0, bunch_req = 0;
    logic [15:0] cmd_addr = 0, cmd_wdata = 0, cmd_rdata, rd_q[$];
    logic cmd_rvalid, pulse_busy, front_trigger_in = 0, term_switch = 0, flash_wr = 0, flash_done = 0;
    logic [9:0] flash_addr = 0;
    logic ext_clock_in = 0, ext_clock_sel = 0;
    logic [7:0] flash_data = 0, lut[1024];  // Own copy of the table
    logic [31:0] ev_word = 0, out_word, w, exp_q[$], msk_q[$];
    logic [1:0] ev_kind = 0;
    logic ev_valid = 0, ev_ready, out_valid, buf_full = 0, buf_pending = 0, global_error = 0;
    logic bunch_reset_pulse, trigger_pulse, clear_active, full_lamp, fault_lamp, data_pending_lamp, ack_lamp, term_lamp;
    int seed = 32'h715C, error_cnt = 0, num_checks = 0;
    tdc_ctrl_if ctrl_if ();
    tdc_readout_host tdc_readout_host_inst (.ref_clk, .reset_n, .ctrl(ctrl_if), .cmd_wr, .cmd_rd, .cmd_addr,
        .cmd_wdata, .cmd_rdata, .cmd_rvalid, .trig_req, .clear_req, .bunch_req, .pulse_busy);
    // Short lamp test keeps the run brief
    tdc_readout_device #(.CONFIG_CYCLES(8)) tdc_readout_device_inst (.ref_clk, .reset_n, .ctrl(ctrl_if),
        .front_trigger_in, .ext_clock_in, .ext_clock_sel, .term_switch, .flash_wr, .flash_addr,
        .flash_data, .flash_done, .ev_word, .ev_kind, .ev_valid, .ev_ready, .out_word, .out_valid, .buf_full,
        .buf_pending, .global_error, .bunch_reset_pulse, .trigger_pulse, .clear_active, .full_lamp, .fault_lamp,
        .data_pending_lamp, .ack_lamp, .term_lamp);
    tdc_ctrl_props tdc_ctrl_props_inst (.ref_clk, .reset_n, .connector_trigger_in(ctrl_if.connector_trigger_in),
        .hard_clear_in(ctrl_if.hard_clear_in), .bunch_count_reset_in(ctrl_if.bunch_count_reset_in),
        .addr(ctrl_if.addr), .wdata(ctrl_if.wdata), .wr(ctrl_if.wr), .rd(ctrl_if.rd), .rdata(ctrl_if.rdata));
    always #10 ref_clk = ~ref_clk;  // 50 MHz
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] e, s, m);
        num_checks++;
        if ((s & m) !== (e & m)) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e & m, s & m);
        end
    endtask : check
    task automatic tally_and_finish;
        if (error_cnt == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    // Register order through the host; ack lamp lights the cycle after the strobe
    task automatic reg_op(input logic wr_not_rd, input logic [15:0] a, d, e);
        cmd_wr <= wr_not_rd;
        cmd_rd <= !wr_not_rd;
        cmd_addr <= a;
        cmd_wdata <= d;
        if (!wr_not_rd)
            rd_q.push_back(e);
        @(posedge ref_clk);
        cmd_wr <= 0;
        cmd_rd <= 0;
        @(posedge ref_clk);
        #1 check("ack_lamp", 1, ack_lamp, 1);
        repeat (3) @(posedge ref_clk);
    endtask : reg_op
    // One word, held one edge; the two spare edges cover the refused cycle after a trailer
    task automatic send(input logic [1:0] k, input logic [31:0] d, e, m);
        ev_kind <= k;
        ev_word <= d;
        ev_valid <= 1;
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge ref_clk);
        ev_valid <= 0;
        repeat (2) @(posedge ref_clk);
    endtask : send
    task automatic wait_hi(input string nm, ref logic s);
        logic seen;
        seen = 0;
        repeat (16) @(posedge ref_clk) if (s === 1'b1) seen = 1;
        check(nm, 1, seen, 1);
    endtask : wait_hi
    function automatic logic [31:0] corr(input logic [31:0] d);
        corr = {d[31:21], d[20:0] - {{13{lut[d[9:0]][7]}}, lut[d[9:0]]}};
    endfunction : corr
    // Oldest note against each result as it appears
    always @(posedge ref_clk) begin
        if (cmd_rvalid === 1'b1)
            check("cmd_rdata", rd_q.pop_front(), cmd_rdata, 32'hFFFF);
        if (out_valid === 1'b1)
            check("out_word", exp_q.pop_front(), out_word, msk_q.pop_front());
    end
    // Watchdog well beyond the expected 1220 cycles
    initial begin
        #100000;
        error_cnt++;
        tally_and_finish();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge ref_clk);
        reset_n <= 1;
        for (int i = 0; i < 1024; i++) begin
            w = $random(seed);
            lut[i] = w[7:0];
            flash_wr <= 1;
            flash_addr <= i[9:0];
            flash_data <= w[7:0];
            @(posedge ref_clk);
        end
        flash_wr <= 0;
        #1 check("config lamps", 3'b111, {full_lamp, fault_lamp, data_pending_lamp}, 7);
        @(posedge ref_clk);
        flash_done <= 1;
        for (int j = 0; j < 4; j++) begin
            w = $random(seed);
            {buf_full, buf_pending, global_error, term_switch} <= w[3:0];
            repeat (8) @(posedge ref_clk);
            check("lamps", w[3:0], {full_lamp, data_pending_lamp, fault_lamp, term_lamp}, 15);
        end
        reg_op(0, 16'h1002, 0, {12'h000, w[1], w[2], w[3], 1'b0});
        reg_op(0, 16'h1000, 0, 16'h0020);
        reg_op(0, 16'h0004, 0, 16'h0000);
        for (int j = 0; j < 4; j++) begin
            w = $random(seed);
            send(1, w, corr(w), 32'hFFFFFFFF);
        end
        send(2, 32'hF0F0F0F5, 32'hF0F0F0F5, 32'hFFFFFFFF);
        reg_op(1, 16'h1000, 16'h0220, 0);
        send(2, 32'h12345678, 32'h12345678, 32'hFFFFFFFF);
        reg_op(1, 16'h1000, 16'h0A00, 0);
        w = $random(seed);
        send(1, w, w, 32'hFFFFFFFF);
        front_trigger_in <= 1;
        repeat (2) @(posedge ref_clk);
        front_trigger_in <= 0;
        wait_hi("trigger_pulse", trigger_pulse);
        ext_clock_sel <= 1;
        clear_req <= 1;
        @(posedge ref_clk);
        clear_req <= 0;
        wait_hi("clear_active", clear_active);
        repeat (8) @(posedge ref_clk);
        bunch_req <= 1;
        @(posedge ref_clk);
        bunch_req <= 0;
        wait_hi("bunch_reset_pulse", bunch_reset_pulse);
        repeat (8) @(posedge ref_clk);
        repeat (5) begin
            ext_clock_in <= 1;
            repeat (2) @(posedge ref_clk);
            ext_clock_in <= 0;
            repeat (2) @(posedge ref_clk);
        end
        trig_req <= 1;
        @(posedge ref_clk);
        trig_req <= 0;
        wait_hi("trigger_pulse", trigger_pulse);
        exp_q.push_back(32'h88000000);
        msk_q.push_back(32'hFFFFFFFF);
        send(2, 32'hABCDEF1F, 32'hABCDEF05, 32'hFFFFFFFF);
        @(posedge ref_clk);
        check("notes left", 0, exp_q.size() + rd_q.size(), 32'hFF);
        tally_and_finish();
    end
endmodule : tb_tdc_timetag_inl_readout
`default_nettype wire
